// ==== include/pcb_regs.svh ====
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from the configuration bank files
`ifndef PCB_REGS_SVH
`define PCB_REGS_SVH

`define PCB_ADDR_SYNC_PERIOD   6'h10
`define PCB_ADDR_CONFIG_A      6'h11
`define PCB_ADDR_FORMAT_A      6'h12
`define PCB_ADDR_FORMAT_B      6'h13
`define PCB_ADDR_FORMAT_C      6'h14
`define PCB_ADDR_COMMAND       6'h1E

`define PCB_RST_SYNC_PERIOD    16'h0909
`define PCB_RST_CONFIG_A       16'h0101
`define PCB_RST_FORMAT         16'h0514

`define PCB_MASK_CONFIG_A      16'hBFF7
`define PCB_MASK_FORMAT_A      16'h1FFF
`define PCB_MASK_FORMAT_BC     16'h0FFF

`define PCB_CMD_END_PROGRAMMING_PHASE       16'h1111

`define PCB_BIT_ODD_CHECK      15
`define PCB_BIT_STEP_VOLT      13
`define PCB_BIT_PIN_ROLE       12
`define PCB_BIT_INIT_CAPTURE   7
`define PCB_BIT_SYNC_MODE      0
`define PCB_BIT_BOOT_DISABLE   12

`define PCB_SYNC_BASE_US       14'h00C8
`define PCB_SYNC_STEP_US       14'h0020
`define PCB_CLK_PERIOD_NS      20
`define PCB_US_CYCLES          (1000 / `PCB_CLK_PERIOD_NS)

`define PCB_LEN_MIN            5'h08
`define PCB_LEN_MAX            5'h1C
`define PCB_LEN_DEFAULT        5'h14
`define PCB_SLOTS_DEFAULT      3'h3
`define PCB_SLOTS_MAX          3'h6

`endif

// ==== include/pcb_pkg.sv ====
// Types shared by the configuration bank and its bench
// Assumes nothing beyond a SystemVerilog compiler
package pcb_pkg;
   typedef enum logic [1:0] {
      PCB_MON_OFF,
      PCB_MON_STANDARD,
      PCB_MON_SIMPLE
   } pcb_mon_t;

   typedef enum logic [1:0] {
      PCB_CUR_19MA,
      PCB_CUR_35MA,
      PCB_CUR_45MA
   } pcb_cur_t;

   typedef enum logic [1:0] {
      PCB_RATE_125K,
      PCB_RATE_189K,
      PCB_RATE_83K
   } pcb_rate_t;
endpackage

// ==== include/pcb_sync_if.sv ====
// Carrier between the bank and one sync spacing timer
// Assumes one clock shared by both ends
`timescale 1ns/100ps
interface pcb_sync_if;
   logic       us_tick;
   logic [7:0] code;
   logic       enable;
   logic       auto_mode;
   logic       trigger;
   logic       pulse;
   logic       refused;

   modport bank  (output us_tick, code, enable, auto_mode, trigger,
                  input  pulse, refused);
   modport timer (input  us_tick, code, enable, auto_mode, trigger,
                  output pulse, refused);
endinterface

// ==== logic/pcb_sync_timer.sv ====
// Sync pulse period and minimum spacing timer for one interface
// Assumes a one-cycle microsecond tick from the bank
`timescale 1ns/100ps
`include "pcb_regs.svh"
module pcb_sync_timer (
   input wire logic core_clk,
   input wire logic rst,
   pcb_sync_if.timer sif
);
   logic [13:0] period_us;
   logic [13:0] elapsed;
   logic        ready;

   // Linear code to period map
   assign period_us = `PCB_SYNC_BASE_US
                    + 14'(`PCB_SYNC_STEP_US * {6'h00, sif.code}); // RULE1
   assign ready = elapsed >= period_us;

   // Time since last pulse, saturating
   always_ff @(posedge core_clk) begin
      if (rst) begin
         elapsed <= 14'h3FFF;
      end else if (sif.pulse) begin
         elapsed <= 14'h0000;
      end else if (sif.us_tick && elapsed != 14'h3FFF) begin
         elapsed <= elapsed + 14'h0001;
      end
   end

   // Automatic period, or spacing guard on external triggers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sif.pulse   <= 1'b0;
         sif.refused <= 1'b0;
      end else begin
         sif.pulse   <= 1'b0;
         sif.refused <= 1'b0;
         if (sif.enable && !sif.pulse) begin
            if (sif.auto_mode) begin
               sif.pulse <= ready;
            end else if (sif.trigger) begin
               sif.pulse   <= ready; // RULE3
               sif.refused <= !ready; // RULE3
            end
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   pulse_spacing_a: assert property ( // RULE3
      sif.pulse |=> !sif.pulse [*8])
      else $error("sync pulses closer than the minimum spacing");
   early_refused_a: assert property ( // RULE3
      sif.enable && !sif.auto_mode && sif.trigger && !sif.pulse && !ready
      |=> sif.refused && !sif.pulse)
      else $error("trigger inside the minimum period not refused");
endmodule // pcb_sync_timer

// ==== logic/pcb_bank.sv ====
// Channel one configuration bank with sync period timers
// Assumes a register port already decoded from the serial host link
// Operation
// RULE1 - Sync period is 200 us plus 32 us per code step
// RULE2 - Timer upper byte serves interface 2, lower byte interface 1
// RULE3 - Pin or command triggered syncs keep the period as minimum spacing
// RULE4 - Bit 15 of config register gives odd parity over all bits
// RULE5 - Bit 13 selects 2.5 V step when clear, 3.5 V when set
// RULE6 - Bit 12 makes output pin carry data, or interrupt when set
// RULE7 - Monitoring codes 00 and 11 off, 01 standard, 10 simple
// RULE8 - Current limit 19 mA, 35 mA for 01 and 11, 45 mA for 10
// RULE9 - Bit 7 set stores sensor init data in its buffer
// RULE10 - Slot count codes 1 to 6 give that count, others give three
// RULE11 - Rate 125k for 00 and 11, 189k for 01, 83.3k for 10
// RULE12 - Bit 0 clear runs asynchronously without sync pulses; the code keeps the interface 2 timer enabled
// RULE13 - Config register resets with bits 8 and 0 set only
// RULE14 - Format register bit 12 set disables the bootstrap circuit
// RULE15 - Per slot check bit: clear means CRC, set means parity
// RULE16 - Data length codes 8 to 28 pass, others mean 20 bits
// RULE17 - Even slot uses bits 11 and 10:6, odd slot 5 and 4:0
// RULE18 - Slot one settings apply to all on capture, simple or async
// RULE19 - Shared slot one settings never rewrite the stored fields
// RULE20 - Host should copy slot one settings into other slot fields
// RULE21 - Command 0x1111 locks configuration writes until reset
// RULE22 - Reserved bits ignore writes and read as zero
`timescale 1ns/100ps
`include "pcb_regs.svh"
module pcb_bank #(
   parameter int US_CYCLES = `PCB_US_CYCLES
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [5:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   output logic      [15:0]       reg_rdata,
   output logic                   reg_rd_valid,
   output logic                   wr_refused,
   output logic                   programming_phase,
   input  wire logic [1:0]        sync_auto,
   input  wire logic [1:0]        sync_trigger,
   output logic      [1:0]        sync_pulse,
   output logic      [1:0]        sync_refused,
   output logic                   sync_step_high,
   output logic                   output_pin_interrupt,
   output pcb_pkg::pcb_mon_t      slot_monitoring_select,
   output pcb_pkg::pcb_cur_t      quiescent_limit_select,
   output logic                   init_data_capture,
   output logic      [2:0]        slot_count,
   output pcb_pkg::pcb_rate_t     bit_rate_select,
   output logic                   synchronous_mode_select,
   output logic                   bootstrap_disable,
   output logic      [5:0][4:0]   slot_data_length,
   output logic      [5:0]        slot_check_parity,
   output logic                   config_a_parity_ok
);
   logic [15:0]      sync_period_timer;
   logic [15:0]      channel_one_config_a;
   logic [2:0][15:0] slot_format;
   logic [5:0]       us_div;
   logic             us_tick;
   logic             wr_cfg;
   logic             wr_cfg_ok;
   logic             slot_share;
   logic [2:0]       count_code;
   logic [15:0]      next_rdata;

   // Configuration writes only while programming is open
   assign wr_cfg = reg_wr && reg_addr >= `PCB_ADDR_SYNC_PERIOD
                   && reg_addr <= `PCB_ADDR_FORMAT_C;
   assign wr_cfg_ok = wr_cfg && programming_phase // RULE21
                      && (reg_addr != `PCB_ADDR_CONFIG_A
                          || ^reg_wdata); // RULE4

   // End of programming latch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         programming_phase <= 1'b1;
      end else if (reg_wr && reg_addr == `PCB_ADDR_COMMAND
                   && reg_wdata == `PCB_CMD_END_PROGRAMMING_PHASE) begin
         programming_phase <= 1'b0; // RULE21
      end
   end

   // Refusal of locked or bad-parity writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_refused <= 1'b0;
      end else begin
         wr_refused <= wr_cfg && !wr_cfg_ok;
      end
   end

   // Sync period timer register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_period_timer <= `PCB_RST_SYNC_PERIOD; // RULE2
      end else if (wr_cfg_ok && reg_addr == `PCB_ADDR_SYNC_PERIOD) begin
         sync_period_timer <= reg_wdata;
      end
   end

   // Channel one configuration register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         channel_one_config_a <= `PCB_RST_CONFIG_A; // RULE13
      end else if (wr_cfg_ok && reg_addr == `PCB_ADDR_CONFIG_A) begin
         channel_one_config_a <= reg_wdata & `PCB_MASK_CONFIG_A; // RULE22
      end
   end

   // Slot format registers, stored as written with reserved bits cleared
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slot_format <= {3{`PCB_RST_FORMAT}};
      end else if (wr_cfg_ok) begin
         case (reg_addr)
            `PCB_ADDR_FORMAT_A: begin
               slot_format[0] <= reg_wdata & `PCB_MASK_FORMAT_A; // RULE22
            end
            `PCB_ADDR_FORMAT_B: begin
               slot_format[1] <= reg_wdata & `PCB_MASK_FORMAT_BC;
            end
            `PCB_ADDR_FORMAT_C: begin
               slot_format[2] <= reg_wdata & `PCB_MASK_FORMAT_BC;
            end
            default: begin
               slot_format <= slot_format;
            end
         endcase
      end
   end

   // Readback of raw register contents
   always_comb begin
      case (reg_addr)
         `PCB_ADDR_SYNC_PERIOD: next_rdata = sync_period_timer;
         `PCB_ADDR_CONFIG_A:    next_rdata = channel_one_config_a;
         `PCB_ADDR_FORMAT_A:    next_rdata = slot_format[0]; // RULE19
         `PCB_ADDR_FORMAT_B:    next_rdata = slot_format[1]; // RULE19
         `PCB_ADDR_FORMAT_C:    next_rdata = slot_format[2]; // RULE19
         default:               next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata    <= 16'h0000;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // Microsecond tick divider
   always_ff @(posedge core_clk) begin
      if (rst) begin
         us_div <= 6'h00;
      end else if (us_div == 6'(US_CYCLES - 1)) begin
         us_div <= 6'h00;
      end else begin
         us_div <= us_div + 6'h01;
      end
   end
   assign us_tick = us_div == 6'(US_CYCLES - 1);

   // Field decode
   assign config_a_parity_ok = ^channel_one_config_a; // RULE4
   assign sync_step_high = channel_one_config_a[`PCB_BIT_STEP_VOLT]; // RULE5
   assign output_pin_interrupt =
      channel_one_config_a[`PCB_BIT_PIN_ROLE]; // RULE6
   assign init_data_capture =
      channel_one_config_a[`PCB_BIT_INIT_CAPTURE]; // RULE9
   assign synchronous_mode_select =
      channel_one_config_a[`PCB_BIT_SYNC_MODE]; // RULE12
   assign bootstrap_disable = slot_format[0][`PCB_BIT_BOOT_DISABLE]; // RULE14

   always_comb begin
      case (channel_one_config_a[11:10])
         2'h1:    slot_monitoring_select = pcb_pkg::PCB_MON_STANDARD; // RULE7
         2'h2:    slot_monitoring_select = pcb_pkg::PCB_MON_SIMPLE; // RULE7
         default: slot_monitoring_select = pcb_pkg::PCB_MON_OFF; // RULE7
      endcase
   end

   always_comb begin
      case (channel_one_config_a[9:8])
         2'h0:    quiescent_limit_select = pcb_pkg::PCB_CUR_19MA; // RULE8
         2'h2:    quiescent_limit_select = pcb_pkg::PCB_CUR_45MA; // RULE8
         default: quiescent_limit_select = pcb_pkg::PCB_CUR_35MA; // RULE8
      endcase
   end

   always_comb begin
      case (channel_one_config_a[2:1])
         2'h1:    bit_rate_select = pcb_pkg::PCB_RATE_189K; // RULE11
         2'h2:    bit_rate_select = pcb_pkg::PCB_RATE_83K; // RULE11
         default: bit_rate_select = pcb_pkg::PCB_RATE_125K; // RULE11
      endcase
   end

   assign count_code = channel_one_config_a[6:4];
   assign slot_count = (count_code == 3'h0 || count_code > `PCB_SLOTS_MAX)
                       ? `PCB_SLOTS_DEFAULT : count_code; // RULE10

   // Slot one settings govern all slots in these modes
   assign slot_share = init_data_capture
                       || channel_one_config_a[11:10] == 2'h2
                       || !synchronous_mode_select; // RULE18

   for (genvar s = 0; s < 6; s++) begin : g_slot
      logic [5:0] raw;
      logic [5:0] eff;
      assign raw = (s % 2 == 0) ? slot_format[s / 2][5:0]
                                : slot_format[s / 2][11:6]; // RULE17
      assign eff = slot_share ? slot_format[0][5:0] : raw; // RULE18
      assign slot_check_parity[s] = eff[5]; // RULE15
      assign slot_data_length[s] =
         (eff[4:0] >= `PCB_LEN_MIN && eff[4:0] <= `PCB_LEN_MAX)
         ? eff[4:0] : `PCB_LEN_DEFAULT; // RULE16
   end

   // Sync timers, index 0 is interface 1
   for (genvar i = 0; i < 2; i++) begin : g_sync
      pcb_sync_if sif ();
      assign sif.us_tick   = us_tick;
      assign sif.code      = sync_period_timer[8 * i +: 8]; // RULE2
      assign sif.enable    = (i == 1) || synchronous_mode_select; // RULE12
      assign sif.auto_mode = sync_auto[i];
      assign sif.trigger   = sync_trigger[i];
      assign sync_pulse[i]   = sif.pulse;
      assign sync_refused[i] = sif.refused;
      pcb_sync_timer u_timer (
         .core_clk (core_clk),
         .rst      (rst),
         .sif      (sif.timer)
      );
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   lock_holds_a: assert property ( // RULE21
      !programming_phase |=> !programming_phase)
      else $error("programming phase reopened without reset");
   end_command_a: assert property ( // RULE21
      reg_wr && reg_addr == `PCB_ADDR_COMMAND
      && reg_wdata == `PCB_CMD_END_PROGRAMMING_PHASE |=> !programming_phase)
      else $error("end of programming command not taken");
   locked_frozen_a: assert property ( // RULE21
      !programming_phase |=> $stable(channel_one_config_a)
      && $stable(sync_period_timer) && $stable(slot_format))
      else $error("configuration changed after lock");
   parity_guard_a: assert property ( // RULE4
      wr_cfg && reg_addr == `PCB_ADDR_CONFIG_A && !(^reg_wdata)
      |=> wr_refused && $stable(channel_one_config_a))
      else $error("even parity write accepted");
   reserved_zero_a: assert property ( // RULE22
      channel_one_config_a[14] == 1'b0 && channel_one_config_a[3] == 1'b0
      && slot_format[1][15:12] == 4'h0)
      else $error("reserved bit holds a one");
   slot_default_a: assert property ( // RULE10
      (count_code == 3'h0 || count_code == 3'h7) |-> slot_count == 3'h3)
      else $error("slot count fallback wrong");
   share_slots_a: assert property ( // RULE18
      slot_share |-> slot_data_length[5] == slot_data_length[0]
      && slot_check_parity[3] == slot_check_parity[0])
      else $error("slot one settings not shared");
   readback_raw_a: assert property ( // RULE19
      reg_rd && reg_addr == `PCB_ADDR_FORMAT_B
      |=> reg_rd_valid && reg_rdata == $past(slot_format[1]))
      else $error("readback differs from stored field");
   async_quiet_a: assert property ( // RULE12
      !synchronous_mode_select [*2] |-> !sync_pulse[0])
      else $error("sync pulse in asynchronous mode");
   length_default_a: assert property ( // RULE16
      !slot_share && slot_format[1][10:6] == 5'h1D
      |-> slot_data_length[3] == 5'h14)
      else $error("data length fallback wrong");

   lock_seen_c: cover property (
      programming_phase ##1 !programming_phase);
   share_seen_c: cover property (slot_share && init_data_capture);
   pulse_seen_c: cover property (sync_pulse[1]);
   refuse_seen_c: cover property (sync_refused[0]);
endmodule // pcb_bank

// ==== bench/pcb_host_model.sv ====
// Host side model driving the register port and the sync triggers
// Assumes the bank samples its inputs on the rising core_clk edge
`timescale 1ns/100ps
module pcb_host_model (
   input  wire logic        core_clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [5:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   output logic [1:0]       sync_auto,
   output logic [1:0]       sync_trigger,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rd_valid,
   input  wire logic        wr_refused,
   input  wire logic [1:0]  sync_pulse,
   input  wire logic [1:0]  sync_refused,
   output logic             stalled
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
      sync_auto = 2'h0;
      sync_trigger = 2'h0;
      stalled = 1'b0;
   end

   // Sets the top bit so the whole word has odd parity
   function automatic logic [15:0] odd_word(input logic [14:0] v);
      return {~^v, v};
   endfunction

   // Released lines show the inverse of the last value
   task automatic wr(input logic [5:0] a, input logic [15:0] d,
                     output logic refused);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      refused = 1'b0;
      repeat (2) begin
         #1;
         refused = refused | wr_refused;
         @(posedge core_clk);
      end
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      int n;
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      n = 0;
      #1;
      while (reg_rd_valid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      d = reg_rdata;
      stalled = (n == 4);
   endtask

   // One-cycle trigger request, as from the pin or a command
   task automatic trig(input int i, output logic p, output logic r);
      @(posedge core_clk);
      sync_trigger[i] <= 1'b1;
      @(posedge core_clk);
      sync_trigger[i] <= 1'b0;
      p = 1'b0;
      r = 1'b0;
      repeat (2) begin
         #1;
         p = p | sync_pulse[i];
         r = r | sync_refused[i];
         @(posedge core_clk);
      end
   endtask
endmodule // pcb_host_model

// ==== bench/pcb_bank_tb.sv ====
// Self-checking bench for the channel one configuration bank
// Assumes the host model file and the bank compile before this one
`timescale 1ns/100ps
`include "pcb_regs.svh"
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("wrong value at %0t: %0h not %0h", $time, got, exp); \
      end \
   end
module pcb_bank_tb;
   logic                   core_clk, rst, reg_wr, reg_rd, stalled;
   logic [5:0]             reg_addr;
   logic [15:0]            reg_wdata, reg_rdata;
   logic                   reg_rd_valid, wr_refused, programming_phase;
   logic [1:0]             sync_auto, sync_trigger, sync_pulse;
   logic [1:0]             sync_refused;
   logic                   sync_step_high, output_pin_interrupt;
   pcb_pkg::pcb_mon_t      slot_monitoring_select;
   pcb_pkg::pcb_cur_t      quiescent_limit_select;
   pcb_pkg::pcb_rate_t     bit_rate_select;
   logic                   init_data_capture, synchronous_mode_select;
   logic                   bootstrap_disable, config_a_parity_ok;
   logic [2:0]             slot_count;
   logic [5:0][4:0]        slot_data_length;
   logic [5:0]             slot_check_parity;
   int                     fail_count = 0;
   int                     cmp_count = 0;

   pcb_bank #(.US_CYCLES(1)) dut_u (.core_clk, .rst, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .wr_refused,
      .programming_phase, .sync_auto, .sync_trigger, .sync_pulse,
      .sync_refused, .sync_step_high, .output_pin_interrupt,
      .slot_monitoring_select, .quiescent_limit_select, .init_data_capture,
      .slot_count, .bit_rate_select, .synchronous_mode_select,
      .bootstrap_disable, .slot_data_length, .slot_check_parity,
      .config_a_parity_ok);

   pcb_host_model host_u (.core_clk, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .sync_auto, .sync_trigger, .reg_rdata, .reg_rd_valid,
      .wr_refused, .sync_pulse, .sync_refused, .stalled);

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic t_reset();
      logic [15:0] d;
      host_u.rd(`PCB_ADDR_SYNC_PERIOD, d);
      `CHK(d, 16'h0909)
      host_u.rd(`PCB_ADDR_CONFIG_A, d);
      `CHK(d, 16'h0101)
      for (int i = 0; i < 3; i++) begin
         host_u.rd(`PCB_ADDR_FORMAT_A + 6'(i), d);
         `CHK(d, 16'h0514)
      end
      `CHK(programming_phase, 1'b1)
      `CHK(quiescent_limit_select, pcb_pkg::PCB_CUR_35MA)
      `CHK(slot_count, 3'h3)
      `CHK(config_a_parity_ok, 1'b0)
      `CHK(slot_data_length[5], 5'h14)
      $display("test reset done");
   endtask

   // e holds step, pin role, capture and sync mode, top bit first
   task automatic cfg(input logic [14:0] v, input logic [3:0] e,
                      input logic [1:0] m, c, b, input logic [2:0] n);
      logic [15:0] d;
      logic        f;
      host_u.wr(`PCB_ADDR_CONFIG_A, host_u.odd_word(v), f);
      `CHK(f, 1'b0)
      host_u.rd(`PCB_ADDR_CONFIG_A, d);
      `CHK(d, host_u.odd_word(v))
      `CHK(config_a_parity_ok, 1'b1)
      `CHK(sync_step_high, e[3])
      `CHK(output_pin_interrupt, e[2])
      `CHK(slot_monitoring_select, pcb_pkg::pcb_mon_t'(m))
      `CHK(quiescent_limit_select, pcb_pkg::pcb_cur_t'(c))
      `CHK(init_data_capture, e[1])
      `CHK(slot_count, n)
      `CHK(bit_rate_select, pcb_pkg::pcb_rate_t'(b))
      `CHK(synchronous_mode_select, e[0])
   endtask

   task automatic t_config();
      logic [15:0] d;
      logic        f;
      cfg(15'h3463, 4'b1101, 2'd1, 2'd0, 2'd1, 3'h6);
      cfg(15'h0A94, 4'b0010, 2'd2, 2'd2, 2'd2, 3'h1);
      cfg(15'h0F77, 4'b0001, 2'd0, 2'd1, 2'd0, 3'h3);
      host_u.wr(`PCB_ADDR_CONFIG_A, 16'h0000, f);
      `CHK(f, 1'b1)
      host_u.rd(`PCB_ADDR_CONFIG_A, d);
      `CHK(d, host_u.odd_word(15'h0F77))
      $display("test config done");
   endtask

   task automatic t_format();
      logic [14:0] modes [3] = '{15'h0400, 15'h0481, 15'h0801};
      logic [15:0] d;
      logic        f;
      host_u.wr(`PCB_ADDR_CONFIG_A, host_u.odd_word(15'h0401), f);
      host_u.wr(`PCB_ADDR_FORMAT_A, 16'hFA1C, f);
      host_u.wr(`PCB_ADDR_FORMAT_B, 16'hF767, f);
      host_u.wr(`PCB_ADDR_FORMAT_C, 16'h0C0C, f);
      host_u.rd(`PCB_ADDR_FORMAT_A, d);
      `CHK(d, 16'h1A1C)
      host_u.rd(`PCB_ADDR_FORMAT_B, d);
      `CHK(d, 16'h0767)
      `CHK(bootstrap_disable, 1'b1)
      `CHK(slot_data_length,
           {5'h10, 5'h0C, 5'h14, 5'h14, 5'h08, 5'h1C})
      `CHK(slot_check_parity, 6'b100110)
      for (int i = 0; i < 3; i++) begin
         host_u.wr(`PCB_ADDR_CONFIG_A, host_u.odd_word(modes[i]), f);
         `CHK(slot_data_length, {6{5'h1C}})
         `CHK(slot_check_parity, 6'h00)
         host_u.rd(`PCB_ADDR_FORMAT_B, d);
         `CHK(d, 16'h0767)
      end
      // Host confirms slot one settings in the second format word
      host_u.wr(`PCB_ADDR_FORMAT_B, 16'h071C, f);
      host_u.rd(`PCB_ADDR_FORMAT_B, d);
      `CHK(d, 16'h071C)
      `CHK(slot_data_length, {6{5'h1C}})
      host_u.wr(`PCB_ADDR_FORMAT_B, 16'h0767, f);
      $display("test format done");
   endtask

   // Interface 2 spacing is 232 us, interface 1 is 200 us
   task automatic t_sync();
      logic f, p, r;
      host_u.wr(`PCB_ADDR_CONFIG_A, host_u.odd_word(15'h0401), f);
      host_u.wr(`PCB_ADDR_SYNC_PERIOD, 16'h0100, f);
      host_u.trig(1, p, r);
      `CHK(p, 1'b1)
      repeat (215) @(posedge core_clk);
      host_u.trig(1, p, r);
      `CHK({p, r}, 2'b01)
      repeat (20) @(posedge core_clk);
      host_u.trig(1, p, r);
      `CHK(p, 1'b1)
      host_u.trig(0, p, r);
      `CHK(p, 1'b1)
      repeat (185) @(posedge core_clk);
      host_u.trig(0, p, r);
      `CHK({p, r}, 2'b01)
      repeat (15) @(posedge core_clk);
      host_u.trig(0, p, r);
      `CHK(p, 1'b1)
      host_u.wr(`PCB_ADDR_CONFIG_A, host_u.odd_word(15'h0400), f);
      repeat (220) @(posedge core_clk);
      host_u.trig(0, p, r);
      `CHK(p, 1'b0)
      $display("test sync done");
   endtask

   task automatic t_lock();
      logic [15:0] d;
      logic        f;
      host_u.wr(`PCB_ADDR_COMMAND, 16'h5555, f);
      #1;
      `CHK(programming_phase, 1'b1)
      host_u.wr(`PCB_ADDR_COMMAND, 16'h1111, f);
      #1;
      `CHK(programming_phase, 1'b0)
      host_u.wr(`PCB_ADDR_SYNC_PERIOD, 16'h00FF, f);
      `CHK(f, 1'b1)
      host_u.rd(`PCB_ADDR_SYNC_PERIOD, d);
      `CHK(d, 16'h0100)
      host_u.wr(`PCB_ADDR_FORMAT_C, 16'h0000, f);
      host_u.rd(`PCB_ADDR_FORMAT_C, d);
      `CHK(d, 16'h0C0C)
      host_u.rd(6'h05, d);
      `CHK(d, 16'h0000)
      $display("test lock done");
   endtask

   always @(posedge stalled) begin
      fail_count++;
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_config();
      t_format();
      t_sync();
      t_lock();
      print_verdict();
   end
endmodule // pcb_bank_tb
